// *** logic/adcbc_pkg.sv ***
// Constants, types and register map of the converter control block
`default_nettype none
package adcbc_pkg;

  // Result and control pins
  localparam int RES_W = 12;
  localparam int PIN_N = 5;
  localparam int PIN_CE = 0;
  localparam int PIN_CSB = 1;
  localparam int PIN_RDC = 2;
  localparam int PIN_W12 = 3;
  localparam int PIN_BSC = 4;
  localparam logic [3:0] MSB_IDX = 4'hb;
  localparam logic [3:0] SHORT_LSB = 4'h4;
  localparam logic [3:0] LAST_BIT = 4'h0;
  localparam logic [3:0] SHORT_TAIL = 4'h8;

  // Output enable patterns
  localparam logic [RES_W-1:0] OE_NONE = 12'h000;
  localparam logic [RES_W-1:0] OE_ALL = 12'hfff;
  localparam logic [RES_W-1:0] OE_HIGH = 12'hff0;
  localparam logic [RES_W-1:0] OE_LOW = 12'h0ff;

  // Timing
  localparam int CLK_MHZ = 250;
  localparam int BIT_NS = 1000;
  localparam int HS_NS = 500;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] BIT_CYC = CNT_W'(BIT_NS * CLK_MHZ / 1000);
  localparam logic [CNT_W-1:0] HS_CYC =
    CNT_W'((HS_NS * CLK_MHZ + 999) / 1000);

  // Register map
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 12'h008;
  localparam int ST_W = 2;
  localparam int ST_DONE = 0;
  localparam int ST_OVR = 1;
  localparam int RB_SHORT = 12;
  localparam int RB_BUSY = 13;

  typedef enum logic [1:0] {
    ADCBC_IDLE,
    ADCBC_CONV,
    ADCBC_SETTLE
  } adcbc_phase_e;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
    logic psel;
    logic penable;
  } adcbc_apb_s;

  typedef struct packed {
    logic [PIN_N-1:0] s1;
    logic [PIN_N-1:0] s2;
    logic [PIN_N-1:0] s3;
    logic [PIN_N-1:0] flt;
    logic prevStart;
    adcbc_phase_e phase;
    logic shortCyc;
    logic [3:0] bitIdx;
    logic [CNT_W-1:0] cnt;
    logic [RES_W-1:0] sar;
    logic [RES_W-1:0] res;
    logic busyFlag;
    logic [RES_W-1:0] dataOut;
    logic [RES_W-1:0] dataOe;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } adcbc_state_s;

endpackage
`default_nettype wire

// *** logic/adcbc_top.sv ***
// Converter start, successive approximation, output gating and APB slave
`timescale 1ns/1ps
`default_nettype none

module adcbc_top
  import adcbc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic [PIN_N-1:0] ctrlPins,
  input wire logic [RES_W-1:0] sampleCode,
  input wire adcbc_apb_s apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busyFlag,
  output logic [RES_W-1:0] dataOut,
  output logic [RES_W-1:0] dataOe,
  output logic irq
);

  localparam adcbc_state_s ST_RESET = adcbc_state_s'('0);

  adcbc_state_s r;
  adcbc_state_s next_r;

  ////////////////////////////////////////////////////////////////////////////
  // Output decode

  function automatic logic [RES_W-1:0] oeFor(input logic w12,
                                              input logic bsc);
    if (w12) begin
      oeFor = OE_ALL;
    end else if (bsc) begin
      oeFor = OE_LOW;
    end else begin
      oeFor = OE_HIGH;
    end
  endfunction

  function automatic logic [RES_W-1:0] dataFor(input logic w12,
                                                input logic bsc,
                                                input logic [RES_W-1:0] v);
    if (w12) begin
      dataFor = v;
    end else if (bsc) begin
      dataFor = {4'h0, 4'h0, v[3:0]};
    end else begin
      dataFor = {v[RES_W-1:4], 4'h0};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Combinational next state

  logic startCond;
  logic startEdge;
  logic readGate;
  logic [RES_W-1:0] trial;
  logic [RES_W-1:0] kept;
  logic [RES_W-1:0] oeTarget;
  logic apbReqNew;
  logic apbDone;
  logic [ST_W-1:0] stSet;
  logic [ST_W-1:0] stClr;
  logic [3:0] lastBit;

  always_comb begin
    next_r = r;
    stSet = '0;
    stClr = '0;

    // Three-stage pin synchroniser, taken when stages two and three agree
    next_r.s1 = ctrlPins;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < PIN_N; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.flt[i] = r.s3[i];
      end
    end

    startCond = r.flt[PIN_CE] & ~r.flt[PIN_CSB]
                & ~r.flt[PIN_RDC];
    startEdge = startCond & ~r.prevStart;
    next_r.prevStart = startCond;

    if (startEdge) begin
      next_r.shortCyc = r.flt[PIN_BSC];
      if (r.busyFlag) begin
        stSet[ST_OVR] = 1'b1;
      end else begin
        next_r.phase = ADCBC_CONV;
        next_r.busyFlag = 1'b1;
        next_r.bitIdx = MSB_IDX;
        next_r.cnt = BIT_CYC - 1'b1;
        next_r.sar = '0;
      end
    end

    // One bit decided per bit time, MSB first
    trial = r.sar | (RES_W'(1) << r.bitIdx);
    kept = (trial <= sampleCode) ? trial : r.sar;
    lastBit = r.shortCyc ? SHORT_LSB : LAST_BIT;
    unique case (r.phase)
      ADCBC_IDLE: begin
      end
      ADCBC_CONV: begin
        if (r.cnt != '0) begin
          next_r.cnt = r.cnt - 1'b1;
        end else if (r.bitIdx <= lastBit) begin
          next_r.res = r.shortCyc ? {kept[RES_W-1:4], SHORT_TAIL}
                                  : kept;
          next_r.phase = ADCBC_SETTLE;
          next_r.cnt = HS_CYC - 1'b1;
        end else begin
          next_r.sar = kept;
          next_r.bitIdx = r.bitIdx - 1'b1;
          next_r.cnt = BIT_CYC - 1'b1;
        end
      end
      ADCBC_SETTLE: begin
        if (r.cnt != '0) begin
          next_r.cnt = r.cnt - 1'b1;
        end else begin
          next_r.phase = ADCBC_IDLE;
          next_r.busyFlag = 1'b0;
          stSet[ST_DONE] = 1'b1;
        end
      end
    endcase

    // Output buffers with break-before-make between byte patterns
    readGate = r.flt[PIN_RDC] & ~r.busyFlag & r.flt[PIN_CE]
               & ~r.flt[PIN_CSB];
    oeTarget = readGate ? oeFor(r.flt[PIN_W12], r.flt[PIN_BSC])
                        : OE_NONE;
    if (r.dataOe != OE_NONE && oeTarget != OE_NONE
        && oeTarget != r.dataOe) begin
      next_r.dataOe = OE_NONE;
    end else begin
      next_r.dataOe = oeTarget;
    end
    next_r.dataOut = dataFor(r.flt[PIN_W12], r.flt[PIN_BSC],
                             r.res);

    // APB: one wait state, registered answer
    apbReqNew = apbReq.psel & apbReq.penable & ~r.pready;
    apbDone = apbReq.psel & apbReq.penable & r.pready;
    next_r.pready = apbReqNew;
    if (apbReqNew) begin
      next_r.pslverr = 1'b0;
      next_r.prdata = '0;
      unique case (apbReq.paddr)
        ADDR_STATUS: next_r.prdata = 32'(r.status);
        ADDR_MASK: next_r.prdata = 32'(r.mask);
        ADDR_RESULT: begin
          next_r.prdata = 32'(r.res);
          next_r.prdata[RB_SHORT] = r.shortCyc;
          next_r.prdata[RB_BUSY] = r.busyFlag;
        end
        default: next_r.pslverr = 1'b1;
      endcase
    end else if (!apbDone) begin
      next_r.pslverr = 1'b0;
    end
    if (apbDone && apbReq.pwrite && apbReq.paddr == ADDR_MASK) begin
      next_r.mask = apbReq.pwdata[ST_W-1:0];
    end
    if (apbDone && !apbReq.pwrite && apbReq.paddr == ADDR_STATUS) begin
      stClr = r.prdata[ST_W-1:0];
    end

    // Sticky events, a set in the clearing cycle survives
    next_r.status = (r.status & ~stClr) | stSet;
    next_r.irq = |(next_r.status & next_r.mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      r <= ST_RESET;
    end else if (clkEn) begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign busyFlag = r.busyFlag;
  assign dataOut = r.dataOut;
  assign dataOe = r.dataOe;
  assign irq = r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b || !clkEn);

  chk_start_raises_busy: assert property (
    startEdge && !r.busyFlag |=> busyFlag && r.phase == ADCBC_CONV
  ) else $error("start did not raise busy");

  chk_short_captured: assert property (
    startEdge |=> r.shortCyc == $past(r.flt[PIN_BSC])
  ) else $error("byte/short not captured at start");

  chk_short_tail: assert property (
    r.phase == ADCBC_SETTLE && r.shortCyc |-> r.res[3:0] == SHORT_TAIL
  ) else $error("short result tail wrong");

  chk_busy_phase: assert property (
    busyFlag == (r.phase != ADCBC_IDLE)
  ) else $error("busy does not match conversion");

  chk_busy_oe_off: assert property (
    busyFlag |-> dataOe == OE_NONE
  ) else $error("outputs enabled while busy");

  chk_no_restart: assert property (
    startEdge && busyFlag |=> r.status[ST_OVR]
      && !(r.phase == ADCBC_CONV && r.bitIdx == MSB_IDX
           && r.cnt == BIT_CYC - 1'b1)
      && (busyFlag || $past(r.phase) == ADCBC_SETTLE)
  ) else $error("conversion disturbed by repeated start");

  chk_word_all: assert property (
    readGate && r.flt[PIN_W12] && r.dataOe == OE_ALL |=> dataOe == OE_ALL
  ) else $error("word mode lost outputs");

  chk_busy_tail: assert property (
    $rose(r.phase == ADCBC_SETTLE) |-> busyFlag [*8]
  ) else $error("busy fell too early after data valid");

  chk_settle_len: assert property (
    $fell(busyFlag) |-> $past(r.phase) == ADCBC_SETTLE && $past(r.cnt) == '0
  ) else $error("busy fell outside the settle end");

  chk_oe_gate: assert property (
    dataOe != OE_NONE |-> $past(readGate)
  ) else $error("outputs enabled without read gate");

  chk_byte_break: assert property (
    $past(dataOe) != OE_NONE && dataOe != OE_NONE |-> dataOe == $past(dataOe)
  ) else $error("byte switch without break");

  chk_done_irq: assert property (
    $fell(busyFlag) && r.mask[ST_DONE] |-> irq && r.status[ST_DONE]
  ) else $error("done event not signalled");

  chk_settle_min: assert property (
    $rose(r.phase == ADCBC_SETTLE) |-> ##74 busyFlag
  ) else $error("busy fell under 300 ns after data valid");

  chk_settle_max: assert property (
    $rose(r.phase == ADCBC_SETTLE) |-> ##[75:250] !busyFlag
  ) else $error("busy held over 1000 ns after data valid");

  chk_word_data: assert property (
    dataOe == OE_ALL |-> dataOut == r.res
  ) else $error("word read data wrong");

  chk_high_byte: assert property (
    dataOe == OE_HIGH |-> dataOut[RES_W-1:4] == r.res[RES_W-1:4]
  ) else $error("upper byte data wrong");

  chk_low_byte: assert property (
    dataOe == OE_LOW |-> dataOut == {8'h00, r.res[3:0]}
  ) else $error("lower byte data wrong");

  chk_ce_idle: assert property (
    !r.flt[PIN_CE] && !busyFlag |=> !busyFlag && dataOe == OE_NONE
  ) else $error("activity with enable low");

  chk_irq_level: assert property (
    irq == |(r.status & r.mask)
  ) else $error("interrupt level wrong");

  chk_pready_pulse: assert property (
    pready |=> !pready
  ) else $error("ready held over one cycle");

  chk_apb_wait: assert property (
    apbReq.psel && apbReq.penable && !pready |=> pready
  ) else $error("bus answer not after one wait state");

endmodule // adcbc_top
`default_nettype wire

// *** tb/adcbc_strobe_ctl.sv ***
// Controller model that drives the converter's control pins
`timescale 1ns/1ps
`default_nettype none
module adcbc_strobe_ctl
  import adcbc_pkg::*;
(
  input wire logic mclk,
  input wire logic [PIN_N-1:0] want,
  output var logic [PIN_N-1:0] ctrlPins
);
  // 13 cycles of 4 ns cover the 50 ns setup
  localparam int SETTLE_CYC = 13;
  logic [PIN_N-1:0] rdcBit;
  logic [PIN_N-1:0] pinReg = 5'h0d;
  int held = 0;
  assign rdcBit = PIN_N'(1) << PIN_RDC;
  assign ctrlPins = pinReg;
  ////////////////////////////////////////////////////////////////////////
  // Read/convert moves last, after the others have settled
  always @(posedge mclk) begin
    if (((pinReg ^ want) & ~rdcBit) != '0) begin
      pinReg <= (want & ~rdcBit) | (pinReg & rdcBit);
      held <= 0;
    end else if (held < SETTLE_CYC) begin
      held <= held + 1;
    end else begin
      pinReg <= want;
    end
  end
endmodule // adcbc_strobe_ctl
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adcbc_pkg::*;
  logic mclk, rst_b, clkEn, pready, pslverr, busyFlag, irq, err;
  logic [PIN_N-1:0] want, ctrlPins;
  logic [RES_W-1:0] sampleCode, dataOut, dataOe;
  logic [31:0] prdata, rd;
  adcbc_apb_s apbReq;
  int mismatches, tests_run, n;
  adcbc_top i_dut (.mclk(mclk), .rst_b(rst_b), .clkEn(clkEn),
    .ctrlPins(ctrlPins), .sampleCode(sampleCode), .apbReq(apbReq),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busyFlag(busyFlag), .dataOut(dataOut), .dataOe(dataOe), .irq(irq));
  adcbc_strobe_ctl i_ctl (.mclk(mclk), .want(want), .ctrlPins(ctrlPins));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [ADDR_W-1:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge mclk);
    apbReq <= '{a, w, d, 1'b1, 1'b0};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
  // Start, read while busy, optional change at cycle 500, time busy
  task automatic conv(input logic [4:0] p, input logic [4:0] mid,
                      input int len);
    @(posedge mclk);
    want <= p;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (!busyFlag && n < 60);
    chk(busyFlag, 1);
    @(posedge mclk);
    want <= 5'h0d;
    n = 1;
    do begin
      @(negedge mclk);
      n++;
      if (n == 100) chk(dataOe, OE_NONE);
      if (n == 500) begin
        @(posedge mclk);
        want <= mid;
      end
    end while (busyFlag && n < 4000);
    chk(n >= len - 2 && n <= len + 2, 1);
    $display("conversion done t=%0t", $time);
  endtask
  task automatic readPins(input logic [4:0] p, input logic [11:0] oe,
                          input logic [11:0] d);
    @(posedge mclk);
    want <= p;
    repeat (40) @(negedge mclk);
    chk(dataOe, oe);
    chk(dataOut & oe, d);
    $display("pin read done t=%0t", $time);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (50000) @(posedge mclk);
    mismatches++;
    summarize();
  end
  initial begin
    mismatches = 0;
    tests_run = 0;
    rst_b = 1'b0;
    clkEn = 1'b1;
    want = 5'h0d;
    sampleCode = 12'ha5c;
    apbReq = '0;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    apb(ADDR_MASK, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(12'h00c, 1'b0, 32'h0);
    chk(err, 1);
    apb(ADDR_MASK, 1'b1, 32'h3);
    conv(5'h09, 5'h0d, 3125);
    chk(irq, 1);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h1);
    apb(ADDR_RESULT, 1'b0, 32'h0);
    chk(rd, 32'ha5c);
    repeat (2) @(negedge mclk);
    chk(irq, 0);
    readPins(5'h0d, OE_ALL, 12'ha5c);
    readPins(5'h05, OE_HIGH, 12'ha50);
    readPins(5'h15, OE_LOW, 12'h00c);
    readPins(5'h1d, OE_ALL, 12'ha5c);
    // Clock enable low: pin changes ignored, outputs held
    @(posedge mclk);
    clkEn <= 1'b0;
    sampleCode <= 12'h3c7;
    want <= 5'h19;
    repeat (40) @(negedge mclk);
    chk(busyFlag, 0);
    chk(dataOe, OE_ALL);
    $display("freeze done t=%0t", $time);
    @(posedge mclk);
    clkEn <= 1'b1;
    conv(5'h19, 5'h0d, 2125);
    readPins(5'h0d, OE_ALL, 12'h3c8);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h1);
    conv(5'h09, 5'h19, 2125);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h3);
    apb(ADDR_RESULT, 1'b0, 32'h0);
    chk(rd, 32'h13c8);
    // Enable low with read high, then read/convert falls
    @(posedge mclk);
    want <= 5'h0c;
    repeat (60) @(negedge mclk);
    chk(dataOe, OE_NONE);
    @(posedge mclk);
    want <= 5'h08;
    repeat (60) @(negedge mclk);
    chk(busyFlag, 0);
    conv(5'h09, 5'h0d, 3125);
    summarize();
  end
endmodule // testbench
`default_nettype wire
